//--- core/bsc_pkg.sv
// Constants and types for the bit-skip, clear and compare execute slice.
// Assumes a single core clock and a synchronous register file beside it.
package bsc_pkg;

    // ****************************************
    // Widths and values
    // ****************************************
    localparam int         DATA_W        = 8;
    localparam int         ADDR_W        = 7;
    localparam int         BIT_SEL_W     = 3;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;
    localparam logic [7:0] WORK_RST      = 8'h00;
    localparam logic       FLAG_RST      = 1'b0;
    localparam logic       STATUS_N_RST  = 1'b1;
    localparam logic       DEST_WORK     = 1'b0;
    localparam int         SKIP_CYCLES   = 2;
    localparam int         WDT_W_DEF     = 8;
    localparam int         DIV_W_DEF     = 8;

    // ****************************************
    // Operations
    // ****************************************
    typedef enum logic [2:0] {
        BSC_NOP,
        BSC_SKIP_IF_BIT_SET_OP,
        BSC_CLEAR_WORK_VALUE_OP,
        BSC_CLEAR_FILE_REG_OP,
        BSC_INVERT_FILE_REG_OP,
        BSC_KICK_WATCHDOG_OP,
        BSC_COMPARE_WORK_VALUE_OP
    } bsc_op_type;

endpackage : bsc_pkg

//--- core/bsc_watchdog.sv
// Watchdog counter and the divider it may share with a timer.
// Assumes kick and assignment come from logic on the same clock.
`timescale 1ns/1ns
module bsc_watchdog #(
    parameter int WDT_W = bsc_pkg::WDT_W_DEF,
    parameter int DIV_W = bsc_pkg::DIV_W_DEF
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    // Control
    input  wire logic             i_kick,
    input  wire logic             i_div_to_watchdog,
    // State
    output logic [WDT_W-1:0]      o_watchdog_counter,
    output logic [DIV_W-1:0]      o_shared_divider,
    output logic                  o_timeout
);
    import bsc_pkg::*;

    if (WDT_W < 1 || DIV_W < 1) begin : g_bad_width
        $error("bsc_watchdog: widths must be positive");
    end

    logic div_wrap;
    // Undivided tick when the divider belongs to the timer
    assign div_wrap = i_div_to_watchdog ? (&o_shared_divider) : 1'b1;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_shared_divider <= '0;
        end else if (i_kick && i_div_to_watchdog) begin
            o_shared_divider <= '0;
        end else begin
            o_shared_divider <= o_shared_divider + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_watchdog_counter <= '0;
        end else if (i_kick) begin
            o_watchdog_counter <= '0;
        end else if (div_wrap) begin
            o_watchdog_counter <= o_watchdog_counter + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_timeout <= 1'b0;
        end else begin
            o_timeout <= !i_kick && div_wrap && (&o_watchdog_counter);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_kick_divider: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_kick && i_div_to_watchdog) |=> o_shared_divider == '0)
        else $error("shared divider not cleared by kick");

    a_divider_kept: assert property (
        @(posedge i_clk) disable iff (i_srst)
        (i_kick && !i_div_to_watchdog) |=>
            o_shared_divider == $past(o_shared_divider) + 1'b1)
        else $error("timer divider disturbed by kick");

endmodule : bsc_watchdog

//--- core/bsc_exec.sv
// Execute slice for bit-test skip, clears, complement, watchdog kick and
// compare. Assumes the file register read data for i_file_addr is valid
// combinationally in the cycle the operation is presented.
`timescale 1ns/1ns

// Summary of operation
// - Skip-if-set tests the addressed register bit; skips only when one.
// - Skip discards fetched next instruction, runs a nop; two cycles total.
// - Clear work value loads zero and forces zero flag to one.
// - Clear file register writes zero and sets the zero flag.
// - Invert register; result to work value if dest 0, register if 1.
// - Kick zeroes watchdog counter, and divider only when assigned to it.
// - Kick sets timeout and sleep status (active low) to one; a same-cycle timeout or sleep entry keeps its own bit at zero.
// - Compare subtracts work value from register, updates zero and carry.
// - Compare leaves work value and register unchanged.
module bsc_exec #(
    parameter int WDT_W = bsc_pkg::WDT_W_DEF,
    parameter int DIV_W = bsc_pkg::DIV_W_DEF
) (
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_srst,
    // Instruction from fetch
    input  wire logic                        i_op_valid,
    input  wire bsc_pkg::bsc_op_type         i_op,
    input  wire logic [bsc_pkg::ADDR_W-1:0]  i_file_addr,
    input  wire logic [bsc_pkg::BIT_SEL_W-1:0] i_bit_sel,
    input  wire logic                        i_dest_sel,
    input  wire logic [bsc_pkg::DATA_W-1:0]  i_file_rdata,
    // Watchdog context
    input  wire logic                        i_div_to_watchdog,
    input  wire logic                        i_sleep_entry,
    // File register write
    output logic                             o_file_we,
    output logic [bsc_pkg::ADDR_W-1:0]       o_file_waddr,
    output logic [bsc_pkg::DATA_W-1:0]       o_file_wdata,
    // Core state
    output logic [bsc_pkg::DATA_W-1:0]       o_work_value_reg,
    output logic                             o_zero_flag,
    output logic                             o_carry_flag,
    output logic                             o_skip_next,
    output logic                             o_timeout_status_n,
    output logic                             o_sleep_status_n,
    output logic [WDT_W-1:0]                 o_watchdog_counter,
    output logic [DIV_W-1:0]                 o_shared_divider
);
    import bsc_pkg::*;

    // Counters and divider need at least one bit each
    if (WDT_W < 1 || DIV_W < 1) begin : g_bad_width
        $error("bsc_exec: widths must be positive");
    end

    // ****************************************
    // Decode
    // ****************************************
    typedef enum logic {BSC_RUN, BSC_SQUASH} bsc_state_type;

    function automatic logic bit_of(input logic [DATA_W-1:0] v,
                                    input logic [BIT_SEL_W-1:0] s);
        bit_of = v[s];
    endfunction : bit_of

    bsc_state_type state;
    logic          take;
    logic          is_skip;
    logic          is_clear_work_value_op;
    logic          is_clear_file_reg_op;
    logic          is_inv;
    logic          is_kick;
    logic          is_cmp;
    logic          skip_hit;
    logic [DATA_W-1:0] inv_val;
    logic [DATA_W:0]   cmp_diff;
    logic          timeout;

    // Instruction arriving during the squash cycle is the discarded one
    assign take     = i_op_valid && (state == BSC_RUN);
    assign is_skip  = take && (i_op == BSC_SKIP_IF_BIT_SET_OP);
    assign is_clear_work_value_op  = take && (i_op == BSC_CLEAR_WORK_VALUE_OP);
    assign is_clear_file_reg_op  = take && (i_op == BSC_CLEAR_FILE_REG_OP);
    assign is_inv   = take && (i_op == BSC_INVERT_FILE_REG_OP);
    assign is_kick  = take && (i_op == BSC_KICK_WATCHDOG_OP);
    assign is_cmp   = take && (i_op == BSC_COMPARE_WORK_VALUE_OP);
    assign skip_hit = is_skip && bit_of(i_file_rdata, i_bit_sel);
    assign inv_val  = ~i_file_rdata;
    // Ninth bit is the borrow
    assign cmp_diff = {1'b0, i_file_rdata} - {1'b0, o_work_value_reg};

    // ****************************************
    // Skip sequencing
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state <= BSC_RUN;
        end else begin
            case (state)
                BSC_RUN: begin
                    if (skip_hit) begin
                        state <= BSC_SQUASH;
                    end
                end
                BSC_SQUASH: begin
                    state <= BSC_RUN;
                end
                default: begin
                    state <= BSC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_skip_next <= 1'b0;
        end else begin
            o_skip_next <= skip_hit;
        end
    end

    // ****************************************
    // Work value and file write
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_work_value_reg <= WORK_RST;
        end else if (is_clear_work_value_op) begin
            o_work_value_reg <= ZERO_BYTE;
        end else if (is_inv && i_dest_sel == DEST_WORK) begin
            o_work_value_reg <= inv_val;
        end
    end

    // Compare never reaches the write port
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_file_we    <= 1'b0;
            o_file_waddr <= '0;
            o_file_wdata <= ZERO_BYTE;
        end else begin
            o_file_we    <= is_clear_file_reg_op || (is_inv && i_dest_sel != DEST_WORK);
            o_file_waddr <= i_file_addr;
            o_file_wdata <= is_clear_file_reg_op ? ZERO_BYTE : inv_val;
        end
    end

    // ****************************************
    // Flags
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_zero_flag <= FLAG_RST;
        end else if (is_clear_work_value_op || is_clear_file_reg_op) begin
            o_zero_flag <= 1'b1;
        end else if (is_inv) begin
            o_zero_flag <= (inv_val == ZERO_BYTE);
        end else if (is_cmp) begin
            o_zero_flag <= (cmp_diff[DATA_W-1:0] == ZERO_BYTE);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_carry_flag <= FLAG_RST;
        end else if (is_cmp) begin
            o_carry_flag <= ~cmp_diff[DATA_W];
        end
    end

    // ****************************************
    // Watchdog and status
    // ****************************************
    bsc_watchdog #(
        .WDT_W (WDT_W),
        .DIV_W (DIV_W)
    ) u_watchdog (
        .i_clk              (i_clk),
        .i_srst             (i_srst),
        .i_kick             (is_kick),
        .i_div_to_watchdog  (i_div_to_watchdog),
        .o_watchdog_counter (o_watchdog_counter),
        .o_shared_divider   (o_shared_divider),
        .o_timeout          (timeout)
    );

    // Hardware event wins over a kick in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_timeout_status_n <= STATUS_N_RST;
        end else if (timeout) begin
            o_timeout_status_n <= 1'b0;
        end else if (is_kick) begin
            o_timeout_status_n <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_sleep_status_n <= STATUS_N_RST;
        end else if (i_sleep_entry) begin
            o_sleep_status_n <= 1'b0;
        end else if (is_kick) begin
            o_sleep_status_n <= 1'b1;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_skip_on_set: assert property (
        is_skip |=> (o_skip_next == $past(i_file_rdata[i_bit_sel])))
        else $error("skip pulse does not match tested bit");

    a_squash_one_cycle: assert property (
        skip_hit |=> (state == BSC_SQUASH) ##1 (state == BSC_RUN))
        else $error("squash does not last exactly one cycle");

    a_clear_work: assert property (
        is_clear_work_value_op |=> (o_work_value_reg == ZERO_BYTE) && o_zero_flag)
        else $error("work value clear failed");

    a_clear_file: assert property (
        is_clear_file_reg_op |=> o_file_we && o_file_wdata == ZERO_BYTE && o_zero_flag)
        else $error("file clear failed");

    a_invert_dest: assert property (
        (is_inv && i_dest_sel) |=>
            o_file_we && o_file_wdata == $past(inv_val))
        else $error("invert to file failed");

    a_invert_carry: assert property (
        is_inv |=> $stable(o_carry_flag)
            && o_zero_flag == ($past(inv_val) == ZERO_BYTE))
        else $error("invert flags wrong");

    a_kick_counter: assert property (
        is_kick |=> o_watchdog_counter == '0)
        else $error("watchdog counter not cleared");

    a_kick_status: assert property (
        (is_kick && !timeout && !i_sleep_entry) |=>
            o_timeout_status_n && o_sleep_status_n)
        else $error("status bits not set by kick");

    a_compare_keep: assert property (
        is_cmp |=> !o_file_we && $stable(o_work_value_reg))
        else $error("compare changed state");

    a_compare_flags: assert property (
        is_cmp |=>
            o_carry_flag == ($past(i_file_rdata) >= $past(o_work_value_reg))
            && o_zero_flag
                == ($past(i_file_rdata) == $past(o_work_value_reg)))
        else $error("compare flags wrong");

    c_skip_taken: cover property (skip_hit ##1 o_skip_next);
    c_invert_work: cover property (is_inv && !i_dest_sel);
    c_kick: cover property (is_kick ##1 o_timeout_status_n);
    c_compare_eq: cover property (is_cmp && cmp_diff == '0);

endmodule : bsc_exec

//--- tb/bsc_exec_tb.sv
// Self-checking bench for the bit-skip, clear and compare execute slice.
// Assumes file read data is driven by the bench in the cycle of each op.
`timescale 1ns/1ns

`define CHK(nm, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
        end \
    end

module tb;
    import bsc_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    // Short watchdog so a timeout comes within a few dozen cycles
    localparam int WDT_W = 4;
    localparam int DIV_W = 2;

    logic                 i_clk             = 1'b0;
    logic                 i_srst            = 1'b1;
    logic                 i_op_valid        = 1'b0;
    bsc_op_type           i_op              = BSC_NOP;
    logic [ADDR_W-1:0]    i_file_addr       = 7'h2A;
    logic [BIT_SEL_W-1:0] i_bit_sel         = 3'h0;
    logic                 i_dest_sel        = 1'b0;
    logic [DATA_W-1:0]    i_file_rdata      = 8'h00;
    logic                 i_div_to_watchdog = 1'b0;
    logic                 i_sleep_entry     = 1'b0;
    logic                 o_file_we;
    logic [ADDR_W-1:0]    o_file_waddr;
    logic [DATA_W-1:0]    o_file_wdata;
    logic [DATA_W-1:0]    o_work_value_reg;
    logic                 o_zero_flag;
    logic                 o_carry_flag;
    logic                 o_skip_next;
    logic                 o_timeout_status_n;
    logic                 o_sleep_status_n;
    logic [WDT_W-1:0]     o_watchdog_counter;
    logic [DIV_W-1:0]     o_shared_divider;
    logic [DIV_W-1:0]     prev_div;
    int                   error_cnt   = 0;
    int                   comparisons = 0;
    int                   i;

    always #20 i_clk = ~i_clk;

    bsc_exec #(.WDT_W(WDT_W), .DIV_W(DIV_W)) uut (
        .i_clk(i_clk), .i_srst(i_srst), .i_op_valid(i_op_valid),
        .i_op(i_op), .i_file_addr(i_file_addr), .i_bit_sel(i_bit_sel),
        .i_dest_sel(i_dest_sel), .i_file_rdata(i_file_rdata),
        .i_div_to_watchdog(i_div_to_watchdog),
        .i_sleep_entry(i_sleep_entry), .o_file_we(o_file_we),
        .o_file_waddr(o_file_waddr), .o_file_wdata(o_file_wdata),
        .o_work_value_reg(o_work_value_reg), .o_zero_flag(o_zero_flag),
        .o_carry_flag(o_carry_flag), .o_skip_next(o_skip_next),
        .o_timeout_status_n(o_timeout_status_n),
        .o_sleep_status_n(o_sleep_status_n),
        .o_watchdog_counter(o_watchdog_counter),
        .o_shared_divider(o_shared_divider)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic final_report;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // One op, then an idle cycle; results are sampled after it lands
    task automatic exec(input bsc_op_type op, input logic [7:0] rd,
                        input logic [2:0] bs, input logic d);
        @(posedge i_clk);
        i_op_valid   <= 1'b1;
        i_op         <= op;
        i_file_rdata <= rd;
        i_bit_sel    <= bs;
        i_dest_sel   <= d;
        #1 prev_div = o_shared_divider;
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        #1;
    endtask : exec

    // Skip test followed back to back by a clear that must be dropped when the tested bit is one
    task automatic skip_case(input logic [2:0] bs, input logic exp);
        exec(BSC_INVERT_FILE_REG_OP, 8'hED, 3'h0, 1'b0);
        @(posedge i_clk);
        i_op_valid   <= 1'b1;
        i_op         <= BSC_SKIP_IF_BIT_SET_OP;
        i_file_rdata <= 8'h5A;
        i_bit_sel    <= bs;
        @(posedge i_clk);
        i_op <= BSC_CLEAR_WORK_VALUE_OP;
        #1 `CHK("skip", exp, o_skip_next)
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        #1 `CHK("skipped work", exp ? 8'h12 : 8'h00, o_work_value_reg)
        `CHK("skip end", 1'b0, o_skip_next)
    endtask : skip_case

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge i_clk);
        i_srst <= 1'b0;
        #1 `CHK("rst work", 8'h00, o_work_value_reg)
        `CHK("rst to_n", 1'b1, o_timeout_status_n)
        exec(BSC_INVERT_FILE_REG_OP, 8'hA6, 3'h0, 1'b0);
        `CHK("inv work", 8'h59, o_work_value_reg)
        `CHK("inv zero", 1'b0, o_zero_flag)
        `CHK("inv nowr", 1'b0, o_file_we)
        exec(BSC_CLEAR_WORK_VALUE_OP, 8'h77, 3'h0, 1'b0);
        `CHK("clr work", 8'h00, o_work_value_reg)
        `CHK("clr zero", 1'b1, o_zero_flag)
        exec(BSC_INVERT_FILE_REG_OP, 8'hED, 3'h0, 1'b0);
        exec(BSC_COMPARE_WORK_VALUE_OP, 8'h11, 3'h0, 1'b0);
        `CHK("cmp lt c", 1'b0, o_carry_flag)
        `CHK("cmp lt z", 1'b0, o_zero_flag)
        exec(BSC_COMPARE_WORK_VALUE_OP, 8'h12, 3'h0, 1'b0);
        `CHK("cmp eq c", 1'b1, o_carry_flag)
        `CHK("cmp eq z", 1'b1, o_zero_flag)
        exec(BSC_COMPARE_WORK_VALUE_OP, 8'h34, 3'h0, 1'b0);
        `CHK("cmp gt c", 1'b1, o_carry_flag)
        `CHK("cmp gt z", 1'b0, o_zero_flag)
        `CHK("cmp work", 8'h12, o_work_value_reg)
        `CHK("cmp nowr", 1'b0, o_file_we)
        exec(BSC_INVERT_FILE_REG_OP, 8'hFF, 3'h0, 1'b1);
        `CHK("inv we", 1'b1, o_file_we)
        `CHK("inv addr", 7'h2A, o_file_waddr)
        `CHK("inv wdata", 8'h00, o_file_wdata)
        `CHK("inv z1", 1'b1, o_zero_flag)
        `CHK("inv c", 1'b1, o_carry_flag)
        `CHK("inv keep", 8'h12, o_work_value_reg)
        exec(BSC_INVERT_FILE_REG_OP, 8'h00, 3'h0, 1'b1);
        `CHK("inv wdata2", 8'hFF, o_file_wdata)
        `CHK("inv z0", 1'b0, o_zero_flag)
        exec(BSC_CLEAR_FILE_REG_OP, 8'h55, 3'h0, 1'b0);
        `CHK("clrf we", 1'b1, o_file_we)
        `CHK("clrf data", 8'h00, o_file_wdata)
        `CHK("clrf zero", 1'b1, o_zero_flag)
        `CHK("clrf work", 8'h12, o_work_value_reg)
        @(posedge i_clk);
        #1 `CHK("clrf strobe", 1'b0, o_file_we)
        for (i = 0; i < 8; i++) begin
            skip_case(i[2:0], i[2:0] inside {3'h1,3'h3,3'h4,3'h6});
        end
        for (i = 0; i < 200 && o_timeout_status_n !== 1'b0; i++) begin
            @(posedge i_clk);
            #1;
        end
        // A used-up bound counts as a mismatch and skips the kick checks
        `CHK("timeout seen", 1'b0, o_timeout_status_n)
        if (o_timeout_status_n === 1'b0) begin
            exec(BSC_KICK_WATCHDOG_OP, 8'h00, 3'h0, 1'b0);
            `CHK("kick cnt", 4'h0, o_watchdog_counter)
            `CHK("kick div", prev_div + 2'h1, o_shared_divider)
            `CHK("kick to_n", 1'b1, o_timeout_status_n)
            @(posedge i_clk);
            i_sleep_entry     <= 1'b1;
            i_div_to_watchdog <= 1'b1;
            @(posedge i_clk);
            i_sleep_entry <= 1'b0;
            #1 `CHK("sleep_n", 1'b0, o_sleep_status_n)
            exec(BSC_KICK_WATCHDOG_OP, 8'h00, 3'h0, 1'b0);
            `CHK("kick cnt2", 4'h0, o_watchdog_counter)
            `CHK("kick div2", 2'h0, o_shared_divider)
            `CHK("kick sl_n", 1'b1, o_sleep_status_n)
        end
        final_report();
    end

endmodule : tb
